/* File: verilog/dtsp_timer.v */
//
// Contract
// - Run/stop bits 7..4 read as one; writes to them ignored.
// - Counter counts while its run bit is one, holds otherwise; run bits reset zero.
// - Hold bits at 2 and 3 reset one; zero means halt on register A match.
// - Writing one to a run bit sets it regardless of hold bit.
// - Writing zero to a run bit clears it only when hold bit is one.
// - With hold bit zero, a register A match clears that run bit.
// - Each of eight pins is a level output or a sampled input, by direction config.
// - Channel 0 pin A can also be the external count clock input.
// - Ch0 pins B, D and ch1 pins B, C, D can drive PWM outputs.
// - Ch0 pin C and ch1 pin A drive PWM only in synchronous PWM modes.
// - A shared input pin disables all timer outputs.
`include "dtsp_defs.vh"

module dtsp_timer (
    input wire clk,
    input wire rst_n,
    input wire [3:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdData_ff,
    input wire [7:0] pinIn,
    output reg [7:0] pinOut_ff,
    output reg [7:0] pinOe_ff,
    input wire outputDisableIn,
    output reg [1:0] matchA_ff
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg [3:0] runStop_ff;
    reg [15:0] gra0_ff;
    reg [15:0] gra1_ff;
    reg [15:0] cnt0_ff;
    reg [15:0] cnt1_ff;
    reg [17:0] pinCfg_ff;
    reg [7:0] pinLvl_ff;
    reg [7:0] pinSync1_ff;
    reg [7:0] pinSync2_ff;
    reg [1:0] odSync_ff;
    reg extClkPrev_ff;
    reg [3:0] nxt_runStop;
    reg [31:0] nxt_rdData;

    // Pin bit order: a0,b0,c0,d0,a1,b1,c1,d1.
    wire extClkEn = pinCfg_ff[`DTSP_CFG_EXTCLK];
    wire syncPwm = pinCfg_ff[`DTSP_CFG_SYNCPWM];
    wire [7:0] pinDir = pinCfg_ff[`DTSP_CFG_DIR_LSB +: 8];
    wire [7:0] pinPwm = pinCfg_ff[`DTSP_CFG_PWM_LSB +: 8];
    wire extRise = pinSync2_ff[0] & ~extClkPrev_ff;
    wire tick0 = extClkEn ? extRise : 1'b1;
    wire run0 = runStop_ff[`DTSP_RUN0];
    wire run1 = runStop_ff[`DTSP_RUN1];
    wire match0 = run0 & (cnt0_ff == gra0_ff);
    wire match1 = run1 & (cnt1_ff == gra1_ff);

    // Write decode for one register index.
    function wrHit;
        input wrStb;
        input [3:0] addr;
        input [3:0] off;
        begin
            wrHit = wrStb && (addr == off);
        end
    endfunction

    wire wrRs = wrHit(regWrite, regAddr, `DTSP_OFF_RUNSTOP);
    wire wrGra0 = wrHit(regWrite, regAddr, `DTSP_OFF_GRA0);
    wire wrGra1 = wrHit(regWrite, regAddr, `DTSP_OFF_GRA1);
    wire wrCnt0 = wrHit(regWrite, regAddr, `DTSP_OFF_CNT0);
    wire wrCnt1 = wrHit(regWrite, regAddr, `DTSP_OFF_CNT1);
    wire wrCfg = wrHit(regWrite, regAddr, `DTSP_OFF_PINCFG);
    wire wrLvl = wrHit(regWrite, regAddr, `DTSP_OFF_PINOUT);

    // Pin a0 never carries PWM; pins c0 and a1 only in the synchronous PWM modes.
    function pwmAllowed;
        input [2:0] idx;
        input syncMode;
        begin
            if (idx == 3'h0) begin
                pwmAllowed = 1'b0;
            end else if ((idx == 3'h2) || (idx == 3'h4)) begin
                pwmAllowed = syncMode;
            end else begin
                pwmAllowed = 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Run/stop next state
    // ------------------------------------------------------------------------
    always @* begin
        nxt_runStop = runStop_ff;
        if (wrRs) begin
            nxt_runStop[`DTSP_HOLD0] = regWrData[`DTSP_HOLD0];
            nxt_runStop[`DTSP_HOLD1] = regWrData[`DTSP_HOLD1];
        end
        if (match0 && !runStop_ff[`DTSP_HOLD0]) begin
            nxt_runStop[`DTSP_RUN0] = 1'b0;
        end
        if (match1 && !runStop_ff[`DTSP_HOLD1]) begin
            nxt_runStop[`DTSP_RUN1] = 1'b0;
        end
        if (wrRs && !regWrData[`DTSP_RUN0] && runStop_ff[`DTSP_HOLD0]) begin
            nxt_runStop[`DTSP_RUN0] = 1'b0;
        end
        if (wrRs && !regWrData[`DTSP_RUN1] && runStop_ff[`DTSP_HOLD1]) begin
            nxt_runStop[`DTSP_RUN1] = 1'b0;
        end
        if (wrRs && regWrData[`DTSP_RUN0]) begin
            nxt_runStop[`DTSP_RUN0] = 1'b1;
        end
        if (wrRs && regWrData[`DTSP_RUN1]) begin
            nxt_runStop[`DTSP_RUN1] = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always @* begin
        nxt_rdData = 32'h00000000;
        case (regAddr)
            `DTSP_OFF_RUNSTOP: nxt_rdData = {24'h000000, `DTSP_RS_RSVD, runStop_ff};
            `DTSP_OFF_GRA0: nxt_rdData = {16'h0000, gra0_ff};
            `DTSP_OFF_GRA1: nxt_rdData = {16'h0000, gra1_ff};
            `DTSP_OFF_CNT0: nxt_rdData = {16'h0000, cnt0_ff};
            `DTSP_OFF_CNT1: nxt_rdData = {16'h0000, cnt1_ff};
            `DTSP_OFF_PINCFG: nxt_rdData = {14'h0000, pinCfg_ff};
            `DTSP_OFF_PINOUT: nxt_rdData = {24'h000000, pinLvl_ff};
            `DTSP_OFF_PININ: nxt_rdData = {23'h000000, odSync_ff[1], pinSync2_ff};
            default: nxt_rdData = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Run/stop register
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            runStop_ff <= `DTSP_RS_RESET;
        end else begin
            runStop_ff <= nxt_runStop;
        end
    end

    // ------------------------------------------------------------------------
    // Compare registers
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            gra0_ff <= `DTSP_GRA_RESET;
            gra1_ff <= `DTSP_GRA_RESET;
        end else begin
            if (wrGra0) begin
                gra0_ff <= regWrData[15:0];
            end
            if (wrGra1) begin
                gra1_ff <= regWrData[15:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin configuration and output levels
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            pinCfg_ff <= `DTSP_CFG_RESET;
            pinLvl_ff <= 8'h00;
        end else begin
            if (wrCfg) begin
                pinCfg_ff <= regWrData[17:0];
            end
            if (wrLvl) begin
                pinLvl_ff <= regWrData[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Only the second stage is read, so a metastable first stage never reaches logic.
    always @(posedge clk) begin
        if (!rst_n) begin
            pinSync1_ff <= 8'h00;
            pinSync2_ff <= 8'h00;
            odSync_ff <= 2'h0;
            extClkPrev_ff <= 1'b0;
        end else begin
            pinSync1_ff <= pinIn;
            pinSync2_ff <= pinSync1_ff;
            odSync_ff <= {odSync_ff[0], outputDisableIn};
            extClkPrev_ff <= pinSync2_ff[0];
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            regRdData_ff <= 32'h00000000;
        end else begin
            regRdData_ff <= regRead ? nxt_rdData : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------------
    // Channel 0 counter
    // ------------------------------------------------------------------------
    // A software write to the counter takes priority over counting.
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt0_ff <= `DTSP_CNT_RESET;
        end else if (wrCnt0) begin
            cnt0_ff <= regWrData[15:0];
        end else if (run0 && tick0) begin
            cnt0_ff <= cnt0_ff + `DTSP_CNT_STEP;
        end
    end

    // ------------------------------------------------------------------------
    // Channel 1 counter
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt1_ff <= `DTSP_CNT_RESET;
        end else if (wrCnt1) begin
            cnt1_ff <= regWrData[15:0];
        end else if (run1) begin
            cnt1_ff <= cnt1_ff + `DTSP_CNT_STEP;
        end
    end

    // ------------------------------------------------------------------------
    // Match flags
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            matchA_ff <= 2'h0;
        end else begin
            matchA_ff <= {match1, match0};
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gPin
            wire isExtClk = (gi == 0) && extClkEn;
            wire usePwm = pinPwm[gi] && pwmAllowed(gi, syncPwm);
            always @(posedge clk) begin
                if (!rst_n) begin
                    pinOe_ff[gi] <= 1'b0;
                    pinOut_ff[gi] <= 1'b0;
                end else begin
                    pinOe_ff[gi] <= pinDir[gi] & ~isExtClk & ~odSync_ff[1];
                    pinOut_ff[gi] <= usePwm ? ((gi < 4) ? run0 : run1) & pinLvl_ff[gi]
                        : pinLvl_ff[gi];
                end
            end
        end
    endgenerate

endmodule // dtsp_timer

/* File: common/dtsp_defs.vh */
`ifndef DTSP_DEFS_VH
`define DTSP_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define DTSP_ADDR_W 4
`define DTSP_OFF_RUNSTOP 4'h0
`define DTSP_OFF_GRA0 4'h1
`define DTSP_OFF_GRA1 4'h2
`define DTSP_OFF_CNT0 4'h3
`define DTSP_OFF_CNT1 4'h4
`define DTSP_OFF_PINCFG 4'h5
`define DTSP_OFF_PINOUT 4'h6
`define DTSP_OFF_PININ 4'h7

// ----------------------------------------------------------------------------
// Run/stop control fields
// ----------------------------------------------------------------------------
`define DTSP_RUN0 0
`define DTSP_RUN1 1
`define DTSP_HOLD0 2
`define DTSP_HOLD1 3
`define DTSP_RS_RSVD 4'hF
`define DTSP_RS_RESET 4'hC

// ----------------------------------------------------------------------------
// Counter and compare register values
// ----------------------------------------------------------------------------
`define DTSP_GRA_RESET 16'hFFFF
`define DTSP_CNT_RESET 16'h0000
`define DTSP_CNT_STEP 16'h0001

// ----------------------------------------------------------------------------
// Pin configuration fields
// ----------------------------------------------------------------------------
`define DTSP_CFG_DIR_LSB 0
`define DTSP_CFG_PWM_LSB 8
`define DTSP_CFG_EXTCLK 16
`define DTSP_CFG_SYNCPWM 17
`define DTSP_CFG_RESET 18'h00000

`endif

/* File: tb/dtsp_timer_chk.sv */
module dtsp_timer_chk (
    input logic clk,
    input logic rst_n,
    input logic [3:0] regAddr,
    input logic [31:0] regWrData,
    input logic regWrite,
    input logic regRead,
    input logic [31:0] regRdData_ff,
    input logic [7:0] pinOe_ff,
    input logic outputDisableIn,
    input logic [1:0] matchA_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence rsWr(v);
        regWrite && regAddr == 4'h0 && regWrData[3:0] == v;
    endsequence
    sequence rsRd;
        regRead && regAddr == 4'h0;
    endsequence
    rsvd_ones_a: assert property (rsRd |=> regRdData_ff[7:4] == 4'hF)
        else $error("reserved bits not one");
    hold_echo_a: assert property (regWrite && regAddr == 4'h0 ##1 rsRd
        |=> regRdData_ff[3:2] == $past(regWrData[3:2], 2)) else $error("hold bits wrong");
    run_set_a: assert property (rsWr(4'hF) ##1 rsRd |=> regRdData_ff[3:0] == 4'hF)
        else $error("run bits not set");
    run_clear_a: assert property (rsWr(4'hC) ##1 rsWr(4'hC) ##1 rsRd
        |=> regRdData_ff[1:0] == 2'b00) else $error("run bits not cleared");
    rd_idle_a: assert property (!regRead |=> regRdData_ff == 32'h0)
        else $error("read data outside read");
    rd_unmapped_a: assert property (regRead && regAddr[3] |=> regRdData_ff == 32'h0)
        else $error("unmapped read not zero");
    out_disable_a: assert property (outputDisableIn [*4] |=> pinOe_ff == 8'h00)
        else $error("outputs not disabled");
    match_pulse_a: assert property ((matchA_ff & $past(matchA_ff)) == 2'b00)
        else $error("match longer than one cycle");
endmodule // dtsp_timer_chk

bind dtsp_timer dtsp_timer_chk dtsp_timer_chk_i (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData_ff(regRdData_ff), .pinOe_ff(pinOe_ff), .outputDisableIn(outputDisableIn),
    .matchA_ff(matchA_ff));

/* File: tb/dtsp_pin_model.sv */
module dtsp_pin_model (
    input logic [7:0] pinOe,
    input logic [7:0] pinOut,
    input logic [7:0] extLevel,
    output logic [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each pin shows the timer level where it drives and the outside level elsewhere.
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // dtsp_pin_model

/* File: tb/dtsp_timer_tb.sv */
module dtsp_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, regWrite = 0, regRead = 0, outputDisableIn = 0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0, regRdData_ff, v;
    logic [7:0] extLevel = 8'h00, pinIn, pinOut_ff, pinOe_ff, rsM = 8'hFC;
    logic [1:0] matchA_ff;
    integer err_total = 0, n_tests = 0, seed = 1;
    always #5 clk = ~clk;
    dtsp_timer dtsp_timer_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData_ff(regRdData_ff), .pinIn(pinIn), .pinOut_ff(pinOut_ff),
        .pinOe_ff(pinOe_ff), .outputDisableIn(outputDisableIn), .matchA_ff(matchA_ff));
    dtsp_pin_model dtsp_pin_model_i (.pinOe(pinOe_ff), .pinOut(pinOut_ff),
        .extLevel(extLevel), .pinIn(pinIn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic op(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= w;
        regRead <= !w;
        regAddr <= a;
        regWrData <= d;
    endtask
    task automatic idle(input integer n);
        repeat (n) @(posedge clk) {regWrite, regRead} <= 2'b00;
        @(negedge clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        op(1'b0, a, 32'h0);
        idle(1);
        chk(regRdData_ff, exp);
    endtask
    // Model of the run/stop register: a zero only clears a run bit whose hold bit is one.
    task automatic rsW(input logic [7:0] d);
        for (int c = 0; c < 2; c++) begin
            if (d[c]) rsM[c] = 1'b1;
            else if (rsM[c + 2]) rsM[c] = 1'b0;
        end
        rsM[3:2] = d[3:2];
        op(1'b1, 4'h0, {24'h0, d});
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        rdc(4'h0, 32'hFC);
        rsW(8'h00);
        rdc(4'h0, {24'h0, rsM});
        op(1'b1, 4'h1, 32'h5);
        rsW(8'h03);
        idle(20);
        rsM[0] = 1'b0;
        rdc(4'h0, {24'h0, rsM});
        rdc(4'h3, 32'h6);
        rsW(8'h00);
        rdc(4'h0, {24'h0, rsM});
        rsW(8'h0E);
        rdc(4'h0, {24'h0, rsM});
        idle(5);
        rdc(4'h3, 32'h6);
        op(1'b0, 4'h4, 32'h0);
        idle(1);
        v = regRdData_ff;
        idle(5);
        rdc(4'h4, v + 32'h7);
        rsW(8'h0D);
        rdc(4'h0, {24'h0, rsM});
        rsW(8'h0C);
        rsW(8'h0C);
        rdc(4'h0, {24'h0, rsM});
        repeat (8) begin
            v = $random(seed);
            rsW(v[7:0]);
            rdc(4'h0, {24'h0, rsM});
            rdc({1'b1, v[10:8]}, 32'h0);
        end
        op(1'b1, 4'h5, 32'hFF);
        op(1'b1, 4'h6, v);
        idle(3);
        chk(pinOut_ff, v[7:0]);
        chk(pinOe_ff, 8'hFF);
        @(posedge clk) outputDisableIn <= 1'b1;
        idle(5);
        chk(pinOe_ff, 8'h00);
        @(posedge clk) outputDisableIn <= 1'b0;
        op(1'b1, 4'h5, 32'h0);
        extLevel <= v[15:8];
        idle(4);
        rdc(4'h7, {24'h0, v[15:8]});
        @(posedge clk) extLevel <= 8'h00;
        rsW(8'h0C);
        op(1'b1, 4'h3, 32'h0);
        op(1'b1, 4'h1, 32'h3);
        rsW(8'h01);
        idle(12);
        rsM[0] = 1'b0;
        rsW(8'h02);
        rdc(4'h0, {24'h0, rsM});
        rdc(4'h3, 32'h4);
        op(1'b1, 4'h5, 32'h10000);
        op(1'b1, 4'h3, 32'h0);
        rsW(8'h0D);
        repeat (2) begin
            @(posedge clk) extLevel[0] <= 1'b1;
            idle(3);
            @(posedge clk) extLevel[0] <= 1'b0;
            idle(3);
        end
        rdc(4'h3, 32'h2);
        rsW(8'h0E);
        op(1'b1, 4'h5, 32'h0FFFF);
        op(1'b1, 4'h6, 32'hFF);
        idle(3);
        chk(pinOut_ff, 8'hF5);
        op(1'b1, 4'h5, 32'h2FFFF);
        idle(3);
        chk(pinOut_ff, 8'hF1);
        test_done;
    end
endmodule // dtsp_timer_tb
